//--- src/cmd_parser_defines.svh
// constants for the serial remote command interpreter
// assumes a byte-wide receive stream and a byte-wide transmit stream
`ifndef CMD_PARSER_DEFINES_SVH
`define CMD_PARSER_DEFINES_SVH

`define CHR_ESC      8'h1B
`define CHR_CR       8'h0D
`define CHR_LF       8'h0A
`define CHR_SP       8'h20
`define CHR_DOT      8'h2E
`define CHR_ZERO     8'h30
`define CHR_MINUS    8'h2D
`define FRAME_LEN    4'hD
`define MAX_DIGITS   3'h6
`define BAUD_DEFAULT 3'h3
`define CODE_MAX     3'h3
`define BAUD_MAX     3'h7
`define ALARM_CLEAR_VAL 20'h00001

`endif

//--- src/cmd_parser_pkg.sv
// types for the serial remote command interpreter
// assumes the defines header is visible to users of these types
package cmd_parser_pkg;
   typedef enum {PS_IDLE, PS_CODE1, PS_CODE2, PS_SEP, PS_VALUE, PS_SKIP} parse_state_t;
   typedef enum {FN_NONE, FN_BAUD, FN_COPY, FN_FILL, FN_ALARM, FN_PROBE} func_t;
   typedef struct packed
   {
      logic [7:0] data;
      logic       valid;
   } byte_stream_t;
   typedef struct packed
   {
      logic [2:0] serial_speed_code;
      logic [1:0] output_selection_code;
      logic [1:0] trace_fill_code;
      logic [1:0] probe_termination_code;
   } settings_t;
   typedef struct packed
   {
      logic       inch;
      logic       fine;
      logic [3:0] d0;
      logic [3:0] d1;
      logic [3:0] d2;
      logic [3:0] d3;
   } reading_t;
endpackage

//--- src/serial_remote_command_parser.sv
// serial remote command interpreter: parses ESC commands, answers queries,
// emits single reading frames through a two-entry output buffer
// assumes a UART outside delivers received bytes and drains transmit bytes
//
// Operation
// - reading frame is thirteen ASCII bytes
// - four layouts by unit and resolution
// - ESC code RETURN queries present value
// - ESC code space value RETURN sets
// - values are decimal integers, no point
// - 0.01 resolution exchanged times one hundred
// - 0.1 resolution exchanged times ten
// - resolution one exchanged unscaled
// - scale fixed across whole value range
// - speed codes 0-7 map 1200..115200 baud
// - output selection codes 0-3
// - trace fill codes 0-3
// - alarm clear write-only, value 1 clears
// - probe termination codes 0-3
// - default 9600 baud, 8N1, hardware handshake
`include "cmd_parser_defines.svh"

module serial_remote_command_parser
(
   // clock and reset
   input  wire logic                        clk,
   input  wire logic                        rst_b,
   // received bytes from the UART
   input  wire cmd_parser_pkg::byte_stream_t rx,
   // transmit bytes to the UART
   output cmd_parser_pkg::byte_stream_t      tx,
   input  wire logic                        tx_ready,
   // reading to send, taken when idle
   input  wire cmd_parser_pkg::reading_t     reading,
   input  wire logic                        reading_send,
   output logic                             reading_busy,
   // settings and alarm clear
   output cmd_parser_pkg::settings_t         settings,
   output logic                             alarm_clear
);
   import cmd_parser_pkg::*;

   typedef struct packed
   {
      // command parser
      parse_state_t ps;
      func_t        fn;
      logic [7:0]   c1;
      logic [19:0]  value;
      logic [2:0]   ndig;
      settings_t    set;
      logic         alarm;
      // reply / frame generator
      logic         rd_active;
      logic         rp_active;
      logic [3:0]   idx;
      reading_t     rd;
      logic [2:0]   rp_val;
      // two-entry output buffer
      logic [1:0][7:0] buf_data;
      logic [1:0]   cnt;
      logic         out_valid;
      logic [7:0]   out_data;
   } state_t;

   state_t s_reg;
   state_t s_next;

   // decode a two-letter code, either case
   // clearing bit 5 folds lower case letters onto upper case
   function automatic func_t decode(input logic [7:0] a, input logic [7:0] b);
      logic [7:0] ua;
      logic [7:0] ub;
      ua = a & 8'hDF;
      ub = b & 8'hDF;
      case ({ua, ub})
         {8'h42, 8'h52}: decode = FN_BAUD;
         {8'h43, 8'h4D}: decode = FN_COPY;
         {8'h46, 8'h49}: decode = FN_FILL;
         {8'h41, 8'h58}: decode = FN_ALARM;
         {8'h50, 8'h47}: decode = FN_PROBE;
         default:        decode = FN_NONE;
      endcase
   endfunction

   // frame byte for position i of a reading
   function automatic logic [7:0] frame_byte(input reading_t r, input logic [3:0] i);
      logic [7:0] dg [4];
      logic [2:0] dot_pos;
      dg[0] = `CHR_ZERO | {4'h0, r.d0};
      dg[1] = `CHR_ZERO | {4'h0, r.d1};
      dg[2] = `CHR_ZERO | {4'h0, r.d2};
      dg[3] = `CHR_ZERO | {4'h0, r.d3};
      // point after one, two or three integer digits; fine picks the
      // two-digit layout in either unit
      dot_pos = r.fine ? 3'h3 : (r.inch ? 3'h2 : 3'h4);
      frame_byte = `CHR_SP;
      // index 0 is the leading blank; 1 to 5 carry the digits and point
      case (i)
         4'h1, 4'h2, 4'h3, 4'h4, 4'h5:
         begin
            if (i[2:0] == dot_pos)
               frame_byte = `CHR_DOT;
            // digits ahead of the point keep their print order
            else if (i[2:0] < dot_pos)
               frame_byte = dg[2'(i - 4'h1)];
            // the point takes one slot, so later digits step back by one
            else
               frame_byte = dg[2'(i - 4'h2)];
         end
         // unit letters IN or MM
         4'h7:    frame_byte = r.inch ? 8'h49 : 8'h4D;
         4'h8:    frame_byte = r.inch ? 8'h4E : 8'h4D;
         // line end
         4'hB:    frame_byte = `CHR_CR;
         4'hC:    frame_byte = `CHR_LF;
         default: frame_byte = `CHR_SP;
      endcase
   endfunction

   // range check for a received value
   // alarm clear takes only one, the speed code 0 to 7; the other code fields take 0 to 3
   function automatic logic in_range(input func_t f, input logic [19:0] v);
      case (f)
         FN_BAUD:  in_range = v <= {17'h0, `BAUD_MAX};
         FN_ALARM: in_range = v == `ALARM_CLEAR_VAL;
         FN_NONE:  in_range = 1'b0;
         default:  in_range = v <= {17'h0, `CODE_MAX};
      endcase
   endfunction

   // reply byte for position i: one digit, then CR LF; every supported
   // code is below ten, so no sign, point or second digit is needed
   function automatic logic [7:0] reply_byte(input logic [3:0] i, input logic [2:0] v);
      case (i)
         4'h0:    reply_byte = `CHR_ZERO | {5'h0, v};
         4'h1:    reply_byte = `CHR_CR;
         default: reply_byte = `CHR_LF;
      endcase
   endfunction

   // present value of a readable function, as an unscaled code
   function automatic logic [2:0] present_value(input func_t f, input settings_t st);
      case (f)
         FN_BAUD: present_value = st.serial_speed_code;
         FN_COPY: present_value = {1'b0, st.output_selection_code};
         FN_FILL: present_value = {1'b0, st.trace_fill_code};
         default: present_value = {1'b0, st.probe_termination_code};
      endcase
   endfunction

   logic       rx_take;
   logic       gen_valid;
   logic [7:0] gen_byte;
   logic       buf_push;
   logic       buf_pop;

   // next state
   always_comb
   begin
      s_next = s_reg;
      // alarm clear is a one-cycle pulse
      s_next.alarm = 1'b0;
      // byte from the reply or frame generator; the frame goes first
      gen_valid = s_reg.rd_active | s_reg.rp_active;
      if (s_reg.rd_active)
         gen_byte = frame_byte(s_reg.rd, s_reg.idx);
      else
         gen_byte = reply_byte(s_reg.idx, s_reg.rp_val);
      // buffer: room while fewer than two words held; two entries let the
      // generator run on through a one-cycle stall without losing a byte
      buf_pop  = s_reg.out_valid & tx_ready;
      buf_push = gen_valid & (s_reg.cnt != 2'h2 || buf_pop);
      // parser ignores received bytes while a reply is queued, so any sent then are lost
      rx_take = rx.valid & ~s_reg.rp_active;

      if (buf_pop)
      begin
         s_next.buf_data[0] = s_reg.buf_data[1];
         s_next.cnt = s_reg.cnt - 2'h1;
      end
      if (buf_push)
      begin
         s_next.buf_data[buf_pop ? s_reg.cnt - 2'h1 : s_reg.cnt] = gen_byte;
         s_next.cnt = buf_pop ? s_reg.cnt : s_reg.cnt + 2'h1;
         s_next.idx = s_reg.idx + 4'h1;
         if (s_reg.rd_active && s_reg.idx == `FRAME_LEN - 4'h1)
         begin
            s_next.rd_active = 1'b0;
            s_next.idx = 4'h0;
         end
         // a reply queued behind a frame shares idx, so it waits its turn
         if (!s_reg.rd_active && s_reg.rp_active && s_reg.idx == 4'h2)
         begin
            s_next.rp_active = 1'b0;
            s_next.idx = 4'h0;
         end
      end
      // registered copies, so tx comes straight from a flip-flop
      s_next.out_valid = s_next.cnt != 2'h0;
      s_next.out_data  = s_next.buf_data[0];

      // a new reading frame only starts when the generator is idle
      // reading_send while busy or replying is ignored, not queued;
      // the caller watches reading_busy and asks again
      if (reading_send && !s_next.rd_active && !s_next.rp_active && !gen_valid)
      begin
         s_next.rd = reading;
         s_next.rd_active = 1'b1;
         s_next.idx = 4'h0;
      end

      // command parser
      if (rx_take)
      begin
         // ESC restarts in any state unless a reply is queued, so a host can abandon a half-typed command
         if (rx.data == `CHR_ESC)
            s_next.ps = PS_CODE1;
         else
            case (s_reg.ps)
               PS_CODE1:
               begin
                  s_next.c1 = rx.data;
                  s_next.ps = PS_CODE2;
               end
               PS_CODE2:
               begin
                  // unknown codes decode to FN_NONE and are then dropped
                  s_next.fn = decode(s_reg.c1, rx.data);
                  s_next.ps = PS_SEP;
               end
               PS_SEP:
               begin
                  s_next.ps = PS_IDLE;
                  if (rx.data == `CHR_SP)
                  begin
                     s_next.ps = PS_VALUE;
                     s_next.value = 20'h0;
                     s_next.ndig = 3'h0;
                  end
                  // a query taken mid-frame would splice its reply into the
                  // frame, so it is dropped
                  else if (rx.data == `CHR_CR && s_reg.fn != FN_NONE && s_reg.fn != FN_ALARM
                           && !s_reg.rd_active)
                  begin
                     s_next.rp_active = 1'b1;
                     s_next.idx = 4'h0;
                     s_next.rp_val = present_value(s_reg.fn, s_reg.set);
                  end
               end
               PS_VALUE:
               begin
                  if (rx.data == `CHR_CR)
                  begin
                     s_next.ps = PS_IDLE;
                     // a space then RETURN carries no digits and is dropped
                     // integer applied as is; scale fixed per function
                     if (s_reg.ndig != 3'h0 && in_range(s_reg.fn, s_reg.value))
                        case (s_reg.fn)
                           FN_BAUD:  s_next.set.serial_speed_code = s_reg.value[2:0];
                           FN_COPY:  s_next.set.output_selection_code = s_reg.value[1:0];
                           FN_FILL:  s_next.set.trace_fill_code = s_reg.value[1:0];
                           FN_PROBE: s_next.set.probe_termination_code = s_reg.value[1:0];
                           FN_ALARM: s_next.alarm = 1'b1;
                           default:  s_next.ps = PS_IDLE;
                        endcase
                  end
                  else if (rx.data >= `CHR_ZERO && rx.data <= 8'h39 && s_reg.ndig != `MAX_DIGITS)
                  begin
                     // decimal accumulate, no point accepted; six digits leave
                     // room for values scaled by one hundred or ten
                     s_next.value = 20'((s_reg.value << 3) + (s_reg.value << 1) + {16'h0, rx.data[3:0]});
                     s_next.ndig = s_reg.ndig + 3'h1;
                  end
                  else
                     s_next.ps = PS_SKIP; // malformed: drop until next ESC
               end
               default: s_next.ps = s_reg.ps;
            endcase
      end
   end

   // single state register
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s_reg <= '0;
         s_reg.ps <= PS_IDLE;
         s_reg.fn <= FN_NONE;
         // only the speed code differs from zero, at the 9600 baud code
         s_reg.set.serial_speed_code <= `BAUD_DEFAULT;
      end
      else
         s_reg <= s_next;
   end

   // outputs straight from the state register
   // no logic past the register, so the UART sees settled values early
   assign tx.valid     = s_reg.out_valid;
   assign tx.data      = s_reg.out_data;
   assign reading_busy = s_reg.rd_active;
   assign settings     = s_reg.set;
   assign alarm_clear  = s_reg.alarm;
endmodule

//--- verification/cmd_parser_monitor.sv
// checker for the command interpreter, port view only
// assumes it is bound onto the design top, single clock domain
module cmd_parser_monitor
(
   // clock and reset
   input wire logic                          clk,
   input wire logic                          rst_b,
   // streams and controls
   input wire cmd_parser_pkg::byte_stream_t  rx,
   input wire cmd_parser_pkg::byte_stream_t  tx,
   input wire logic                          tx_ready,
   input wire cmd_parser_pkg::reading_t      reading,
   input wire logic                          reading_send,
   input wire logic                          reading_busy,
   input wire cmd_parser_pkg::settings_t     settings,
   input wire logic                          alarm_clear
);
   timeunit 1ns;
   timeprecision 100ps;
   import cmd_parser_pkg::*;
   logic [2:0] cr_d;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // return bytes of the last three edges; updates may lag by two
   always_ff @(posedge clk or negedge rst_b)
      if (!rst_b)
         cr_d <= 3'h0;
      else
         cr_d <= {cr_d[1:0], rx.valid && rx.data == 8'h0D};
   // frame request while idle, then the leading blank; a RETURN on the
   // edge before may have started a reply that holds the frame off
   sequence frame_go;
      reading_send && !reading_busy && !tx.valid && !cr_d[0];
   endsequence
   sequence first_blank;
      reading_busy ##1 (tx.valid && tx.data == 8'h20);
   endsequence
   reset_values_a: assert property ($rose(rst_b) |-> settings == 9'h0C0 && !tx.valid && !alarm_clear)
      else $error("reset values wrong");
   tx_hold_a: assert property (tx.valid && !tx_ready |=> tx.valid && $stable(tx.data))
      else $error("stalled byte not held");
   clear_pulse_a: assert property (alarm_clear |=> !alarm_clear)
      else $error("alarm clear longer than a pulse");
   clear_cause_a: assert property ($rose(alarm_clear) |-> cr_d != 3'h0)
      else $error("alarm clear without command end");
   setting_cause_a: assert property (!$stable(settings) |-> cr_d != 3'h0)
      else $error("settings moved without command end");
   tx_chars_a: assert property (tx.valid |-> tx.data inside {8'h20, 8'h2E, 8'h0D, 8'h0A, 8'h49, 8'h4E, 8'h4D, [8'h30:8'h39]})
      else $error("byte outside frame alphabet");
   frame_start_a: assert property (frame_go |=> first_blank)
      else $error("frame did not open with blank");
   busy_span_a: assert property ($rose(reading_busy) |-> reading_busy [*8])
      else $error("frame ended too early");
endmodule

bind serial_remote_command_parser cmd_parser_monitor mon (.clk(clk), .rst_b(rst_b), .rx(rx), .tx(tx),
   .tx_ready(tx_ready), .reading(reading), .reading_send(reading_send), .reading_busy(reading_busy),
   .settings(settings), .alarm_clear(alarm_clear));

//--- verification/host_terminal_model.sv
// host terminal model: takes transmit bytes, stalls at random
// assumes one clock; the bench reads the queue of taken bytes
module host_terminal_model
(
   // clock and reset
   input  wire logic                          clk,
   input  wire logic                          rst_b,
   // transmit stream from the interpreter
   input  wire cmd_parser_pkg::byte_stream_t  tx,
   output logic                              tx_ready
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] q[$];
   initial tx_ready = 1'b0;
   // whole bytes taken on valid and ready; ready low two thirds of
   // the time so the two-entry buffer really fills
   always @(posedge clk)
   begin
      if (rst_b && tx.valid === 1'b1 && tx_ready)
         q.push_back(tx.data);
      #1 tx_ready = ($urandom % 3) == 0;
   end
endmodule

//--- verification/serial_remote_command_parser_tb.sv
// bench for the command interpreter: settings, queries, frames
// assumes the host model on the transmit side; bench drives rx
module serial_remote_command_parser_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import cmd_parser_pkg::*;
   logic         clk, rst_b, tx_ready, reading_send, reading_busy, alarm_clear;
   byte_stream_t rx, tx;
   reading_t     reading, r;
   settings_t    settings, ev;
   int           fails = 0, num_checks = 0, pulses = 0;
   string        codes = "brcmfipgaxzq";

   serial_remote_command_parser DUT (.clk(clk), .rst_b(rst_b), .rx(rx), .tx(tx), .tx_ready(tx_ready),
      .reading(reading), .reading_send(reading_send), .reading_busy(reading_busy),
      .settings(settings), .alarm_clear(alarm_clear));
   host_terminal_model host (.clk(clk), .rst_b(rst_b), .tx(tx), .tx_ready(tx_ready));

   // 200 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // alarm pulses counted as they come
   always @(posedge clk)
      if (alarm_clear === 1'b1)
         pulses++;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("ERROR %0t: got %0h want %0h", $time, got, exp);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // inputs always move 1 ns after the rising edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic put(input logic [7:0] b);
      rx = '{b, 1'b1};
      tick(1);
      rx.valid = 1'b0;
      tick(1);
   endtask
   task automatic wait_q(input int n);
      for (int i = 0; i < 400 && host.q.size() < n; i++)
         tick(1);
      if (host.q.size() < n)
      begin
         fails++;
         test_done();
      end
   endtask
   // letters go out in random case
   task automatic cmd(input int f, input bit qry, input int v);
      logic [7:0] cs;
      cs = ($urandom % 2) ? 8'h20 : 8'h00;
      host.q.delete();
      put(8'h1B);
      put(codes[2 * f] ^ cs);
      put(codes[2 * f + 1] ^ cs);
      if (!qry)
      begin
         put(8'h20);
         if (v > 9)
            put(8'(8'h30 + v / 10));
         put(8'(8'h30 + v % 10));
      end
      put(8'h0D);
      tick(20);
   endtask
   function automatic settings_t upd(settings_t s, int f, int v);
      case (f)
         0: s.serial_speed_code = 3'(v);
         1: s.output_selection_code = 2'(v);
         2: s.trace_fill_code = 2'(v);
         default: s.probe_termination_code = 2'(v);
      endcase
      return s;
   endfunction
   // expected frame byte; point moves with unit and resolution
   function automatic logic [7:0] fb(reading_t x, int i);
      int p;
      int k;
      logic [15:0] d;
      p = x.fine ? 2 : (x.inch ? 1 : 3);
      d = {x.d0, x.d1, x.d2, x.d3};
      k = i - 1;
      if (i == 0 || i == 6 || i == 9 || i == 10)
         return 8'h20;
      if (i == 7 || i == 8)
         return x.inch ? (i == 7 ? 8'h49 : 8'h4E) : 8'h4D;
      if (i > 10)
         return i == 11 ? 8'h0D : 8'h0A;
      if (k == p)
         return 8'h2E;
      if (k > p)
         k--;
      return {4'h3, d[15 - 4 * k -: 4]};
   endfunction

   initial
   begin
      rx = '0;
      reading = '0;
      reading_send = 1'b0;
      rst_b = 1'b0;
      void'($urandom(32'h9C36D137));
      tick(6);
      rst_b = 1'b1;
      ev = '{3'h3, 2'h0, 2'h0, 2'h0};
      chk(settings, ev);
      $display("test defaults done");
      for (int f = 0; f < 4; f++)
         for (int v = 0; v <= (f ? 3 : 7); v++)
         begin
            cmd(f, 0, v);
            ev = upd(ev, f, v);
            chk(settings, ev);
            cmd(f, 1, 0);
            wait_q(3);
            chk({host.q[0], host.q[1], host.q[2]}, {8'(8'h30 + v), 16'h0D0A});
         end
      $display("test set and query done");
      for (int f = 0; f < 6; f++)
      begin
         cmd(f == 4 ? 5 : f, f == 5, (f ? 4 : 8) + $urandom % 8);
         chk(settings, ev);
      end
      chk(host.q.size(), 0);
      pulses = 0;
      cmd(4, 0, 0);
      cmd(4, 1, 0);
      chk(pulses + host.q.size(), 0);
      cmd(4, 0, 1);
      chk(pulses, 1);
      $display("test refusals and alarm done");
      for (int i = 0; i < 12; i++)
      begin
         r = {i[1:0], 16'h0};
         for (int k = 0; k < 4; k++)
            r[4 * k +: 4] = i < 4 ? 4'h9 : 4'($urandom % 10);
         host.q.delete();
         reading = r;
         reading_send = 1'b1;
         // one iteration keeps the request up into the busy cycle
         tick(i == 6 ? 2 : 1);
         reading_send = 1'b0;
         // one iteration sends a query mid-frame, which must be dropped
         if (i == 5)
         begin
            put(8'h1B);
            put(8'h62);
            put(8'h72);
            put(8'h0D);
         end
         wait_q(13);
         for (int k = 0; k < 13; k++)
            chk(host.q[k], fb(r, k));
         tick(10);
         chk(reading_busy + host.q.size(), 13);
      end
      $display("test frames done");
      test_done();
   end
endmodule
